// file: design/sro_pkg.sv
package sro_pkg;
    // Global SYSREF control map (byte offsets of 8-bit registers)
    localparam logic [7:0] ADDR_GLOBAL_POWER = 8'h18;
    localparam logic [7:0] ADDR_BIAS_DELAY = 8'h19;
    localparam logic [7:0] ADDR_FB_DIV_LOW = 8'h1a;
    localparam logic [7:0] ADDR_IN_DIV = 8'h1b;
    // Per-output state registers, one byte each, chosen block
    localparam logic [7:0] ADDR_OUT_STATE_BASE = 8'h20;
    localparam int NUM_OUTPUTS = 8;

    // Field positions
    localparam int POS_GLOBAL_PD = 7;
    localparam int POS_BIAS_TYPE = 7;
    localparam int POS_DLC_LSB = 5;
    localparam int POS_FB_DIV_MSB = 0;
    localparam int POS_AMP_LSB = 0;
    localparam int POS_OUT_PD = 2;
    localparam int POS_FORMAT = 3;
    localparam int POS_ENABLE = 4;
    localparam int POS_PREBIAS = 5;
    localparam int POS_SOURCE = 6;

    // Reset values
    localparam logic [7:0] RST_GLOBAL_POWER = 8'h80;
    localparam logic [7:0] RST_BIAS_DELAY = 8'h80;
    localparam logic [7:0] RST_FB_DIV_LOW = 8'h08;
    localparam logic [7:0] RST_IN_DIV = 8'h08;
    localparam logic [7:0] RST_OUT_STATE = 8'h40;

    // Writable bit masks; others read as zero
    localparam logic [7:0] MASK_GLOBAL_POWER = 8'h80;
    localparam logic [7:0] MASK_BIAS_DELAY = 8'he1;
    localparam logic [7:0] MASK_FB_DIV_LOW = 8'hff;
    localparam logic [7:0] MASK_IN_DIV = 8'h7f;
    localparam logic [7:0] MASK_OUT_STATE = 8'h7f;

    // Amplitude codes
    typedef enum logic [1:0] {
        SRO_AMP_250MV = 2'h0,
        SRO_AMP_500MV = 2'h1,
        SRO_AMP_750MV = 2'h2,
        SRO_AMP_1000MV = 2'h3
    } sro_amp_t;

    // Leg level of one output
    typedef enum logic [1:0] {
        SRO_LEG_OFF = 2'h0,
        SRO_LEG_LOW = 2'h1,
        SRO_LEG_XPOINT = 2'h2,
        SRO_LEG_TOGGLE = 2'h3
    } sro_leg_t;

    // Per-output decoded driver state
    typedef struct packed {
        logic powered;
        logic ecl_format;
        sro_amp_t amplitude;
        logic use_sysref;
        sro_leg_t true_leg;
        sro_leg_t comp_leg;
    } sro_drv_t;

    typedef struct packed {
        logic [7:0] adr;
        logic [7:0] dat;
        logic we;
        logic sel;
        logic req;
    } sro_wb_req_t;
endpackage : sro_pkg

// file: design/sro_output_decode.sv
`timescale 1ns/1ns
`default_nettype none
// Turns one output's register byte plus the global bits into driver state
module sro_output_decode (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [7:0] state_reg,
    input wire logic global_pd,
    input wire logic bias_type,
    input wire logic ref_rise,
    input wire logic ref_level,
    output sro_pkg::sro_drv_t drv,
    output logic ref_output_true,
    output logic ref_output_complement
);
    logic armed;
    logic next_armed;
    sro_pkg::sro_drv_t next_drv;
    logic next_true;
    logic next_comp;
    logic out_power_down;
    logic out_format_select;
    logic out_enable;
    logic out_prebias_bit;
    logic out_source_select;

    assign out_power_down = state_reg[sro_pkg::POS_OUT_PD];
    assign out_format_select = state_reg[sro_pkg::POS_FORMAT];
    assign out_enable = state_reg[sro_pkg::POS_ENABLE];
    assign out_prebias_bit = state_reg[sro_pkg::POS_PREBIAS];
    assign out_source_select = state_reg[sro_pkg::POS_SOURCE];

    // Driver state; toggling waits for the first reference rise
    always_comb begin
        next_drv = '0;
        next_armed = armed;
        next_true = 1'b0;
        next_comp = 1'b0;
        if (global_pd || out_power_down) begin
            next_armed = 1'b0;
        end else if (!out_enable) begin
            next_drv.powered = 1'b1;
            next_drv.true_leg = sro_pkg::SRO_LEG_LOW;
            next_drv.comp_leg = sro_pkg::SRO_LEG_LOW;
            next_armed = 1'b0;
        end else begin
            next_drv.powered = 1'b1;
            next_drv.ecl_format = out_format_select;
            next_drv.amplitude = sro_pkg::sro_amp_t'(state_reg[1:0]);
            next_drv.use_sysref = out_source_select;
            if (ref_rise && !(out_prebias_bit && !out_format_select)) begin
                next_armed = 1'b1;
            end
            if (out_format_select) begin
                next_drv.true_leg = armed ? sro_pkg::SRO_LEG_TOGGLE : sro_pkg::SRO_LEG_LOW;
                next_drv.comp_leg = next_drv.true_leg;
                next_true = armed & ref_level;
                next_comp = ~(armed & ref_level);
            end else if (out_prebias_bit) begin
                // Static: a rise does not arm it (armed keeps its value), never toggles
                next_drv.true_leg = bias_type ? sro_pkg::SRO_LEG_XPOINT
                                              : sro_pkg::SRO_LEG_LOW;
                next_drv.comp_leg = next_drv.true_leg;
                next_comp = ~bias_type;
            end else if (armed) begin
                next_drv.true_leg = sro_pkg::SRO_LEG_TOGGLE;
                next_drv.comp_leg = sro_pkg::SRO_LEG_TOGGLE;
                next_true = ref_level;
                next_comp = ~ref_level;
            end else begin
                next_drv.true_leg = bias_type ? sro_pkg::SRO_LEG_XPOINT
                                              : sro_pkg::SRO_LEG_LOW;
                next_drv.comp_leg = next_drv.true_leg;
                next_comp = ~bias_type;
            end
        end
    end

    // Registered driver state
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            armed <= 1'b0;
            drv <= '0;
            ref_output_true <= 1'b0;
            ref_output_complement <= 1'b0;
        end else begin
            armed <= next_armed;
            drv <= next_drv;
            ref_output_true <= next_true;
            ref_output_complement <= next_comp;
        end
    end
endmodule : sro_output_decode
`default_nettype wire

// file: design/sro_wb_slave.sv
`timescale 1ns/1ns
`default_nettype none
// Classic Wishbone slave front: one-cycle ack, registered read data
module sro_wb_slave (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_sel_i,
    input wire logic [7:0] rd_data,
    input wire logic rd_hit,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic [7:0] wb_dat_o,
    output sro_pkg::sro_wb_req_t req
);
    logic next_ack;
    logic next_err;
    logic [7:0] next_dat;
    logic strobe;

    // New request only when no answer is pending
    assign strobe = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    // Write takes effect in the answer cycle, so one write per access
    always_comb begin
        req.adr = wb_adr_i;
        req.dat = wb_dat_i;
        req.we = wb_we_i;
        req.sel = wb_sel_i;
        req.req = strobe && rd_hit;
        next_ack = strobe && rd_hit;
        next_err = strobe && !rd_hit;
        next_dat = (strobe && rd_hit && !wb_we_i) ? rd_data : wb_dat_o;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 8'h00;
        end else begin
            wb_ack_o <= next_ack;
            wb_err_o <= next_err;
            wb_dat_o <= next_dat;
        end
    end
endmodule : sro_wb_slave
`default_nettype wire

// file: design/sro_top.sv
// Function
// - Eight identical per-output state registers
// - Two-bit amplitude 250 to 1000 mV
// - Power-down overrides format, enable, amplitude
// - Format bit: 0 differential, 1 ECL
// - Enable 0 holds output low
// - Global power-down, resets to 1
// - Bias type affects differential outputs only
// - Bias 0, prebias 0: low, toggle later
// - Bias 0, prebias 1: static low
// - Bias 1, prebias 0: crosspoint, toggle later
// - Bias 1, prebias 1: static crosspoint
// - Source select: 0 clock, 1 sysref
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module sro_top (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_sel_i,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic [7:0] wb_dat_o,
    input wire logic ref_in,
    output logic global_ref_power_down,
    output logic bias_type,
    output logic [1:0] delay_unit_multiplier,
    output logic [8:0] calib_feedback_divider,
    output logic [6:0] calib_input_divider_value,
    output sro_pkg::sro_drv_t [7:0] out_drv,
    output logic [7:0] ref_output_true,
    output logic [7:0] ref_output_complement
);
    logic [7:0] sysref_global_power;
    logic [7:0] sysref_bias_and_delay_unit;
    logic [7:0] calib_feedback_divider_low;
    logic [7:0] calib_input_divider;
    logic [7:0] ref_output_state [sro_pkg::NUM_OUTPUTS];
    logic [7:0] next_global_power;
    logic [7:0] next_bias_delay;
    logic [7:0] next_fb_low;
    logic [7:0] next_in_div;
    logic [7:0] next_out_state [sro_pkg::NUM_OUTPUTS];
    logic [7:0] rd_data;
    logic rd_hit;
    logic ref_prev;
    logic ref_rise;
    logic wr;
    sro_pkg::sro_wb_req_t req;

    // Bus front end
    sro_wb_slave u_wb (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .rd_data(rd_data),
        .rd_hit(rd_hit),
        .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o),
        .wb_dat_o(wb_dat_o),
        .req(req)
    );

    assign wr = req.req && req.we && req.sel;

    // Address decode and read mux; unmapped addresses get err
    always_comb begin
        rd_hit = 1'b1;
        rd_data = 8'h00;
        case (req.adr)
            sro_pkg::ADDR_GLOBAL_POWER: rd_data = sysref_global_power;
            sro_pkg::ADDR_BIAS_DELAY: rd_data = sysref_bias_and_delay_unit;
            sro_pkg::ADDR_FB_DIV_LOW: rd_data = calib_feedback_divider_low;
            sro_pkg::ADDR_IN_DIV: rd_data = calib_input_divider;
            default: begin
                if (req.adr[7:3] == sro_pkg::ADDR_OUT_STATE_BASE[7:3]) begin
                    rd_data = ref_output_state[req.adr[2:0]];
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    // Register writes; reserved bits masked so they read zero
    always_comb begin
        next_global_power = sysref_global_power;
        next_bias_delay = sysref_bias_and_delay_unit;
        next_fb_low = calib_feedback_divider_low;
        next_in_div = calib_input_divider;
        for (int i = 0; i < sro_pkg::NUM_OUTPUTS; i++) begin
            next_out_state[i] = ref_output_state[i];
        end
        if (wr) begin
            case (req.adr)
                sro_pkg::ADDR_GLOBAL_POWER:
                    next_global_power = req.dat & sro_pkg::MASK_GLOBAL_POWER;
                sro_pkg::ADDR_BIAS_DELAY:
                    next_bias_delay = req.dat & sro_pkg::MASK_BIAS_DELAY;
                sro_pkg::ADDR_FB_DIV_LOW:
                    next_fb_low = req.dat & sro_pkg::MASK_FB_DIV_LOW;
                sro_pkg::ADDR_IN_DIV:
                    next_in_div = req.dat & sro_pkg::MASK_IN_DIV;
                default: begin
                    if (req.adr[7:3] == sro_pkg::ADDR_OUT_STATE_BASE[7:3]) begin
                        next_out_state[req.adr[2:0]] =
                            req.dat & sro_pkg::MASK_OUT_STATE;
                    end
                end
            endcase
        end
    end

    // Register bank with documented reset values
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sysref_global_power <= sro_pkg::RST_GLOBAL_POWER;
            sysref_bias_and_delay_unit <= sro_pkg::RST_BIAS_DELAY;
            calib_feedback_divider_low <= sro_pkg::RST_FB_DIV_LOW;
            calib_input_divider <= sro_pkg::RST_IN_DIV;
            for (int i = 0; i < sro_pkg::NUM_OUTPUTS; i++) begin
                ref_output_state[i] <= sro_pkg::RST_OUT_STATE;
            end
            ref_prev <= 1'b0;
        end else begin
            sysref_global_power <= next_global_power;
            sysref_bias_and_delay_unit <= next_bias_delay;
            calib_feedback_divider_low <= next_fb_low;
            calib_input_divider <= next_in_div;
            for (int i = 0; i < sro_pkg::NUM_OUTPUTS; i++) begin
                ref_output_state[i] <= next_out_state[i];
            end
            ref_prev <= ref_in;
        end
    end

    // Reference edge detect; input treated as synchronous
    assign ref_rise = ref_in && !ref_prev;

    // Global fields driven straight from the registers
    assign global_ref_power_down = sysref_global_power[sro_pkg::POS_GLOBAL_PD];
    assign bias_type = sysref_bias_and_delay_unit[sro_pkg::POS_BIAS_TYPE];
    assign delay_unit_multiplier =
        sysref_bias_and_delay_unit[sro_pkg::POS_DLC_LSB +: 2];
    assign calib_feedback_divider = {sysref_bias_and_delay_unit[sro_pkg::POS_FB_DIV_MSB],
                                     calib_feedback_divider_low};
    assign calib_input_divider_value = calib_input_divider[6:0];

    // One identical decoder per output
    for (genvar g = 0; g < sro_pkg::NUM_OUTPUTS; g++) begin : g_out
        sro_output_decode u_dec (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .state_reg(ref_output_state[g]),
            .global_pd(global_ref_power_down),
            .bias_type(bias_type),
            .ref_rise(ref_rise),
            .ref_level(ref_in),
            .drv(out_drv[g]),
            .ref_output_true(ref_output_true[g]),
            .ref_output_complement(ref_output_complement[g])
        );
    end
endmodule : sro_top
`default_nettype wire

// file: bench/sro_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
// Bus handshake and register-to-port relations, seen at the top ports only
module sro_top_chk (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_sel_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic [7:0] wb_dat_o,
    input wire logic global_ref_power_down,
    input wire logic bias_type,
    input wire sro_pkg::sro_drv_t [7:0] out_drv,
    input wire logic [7:0] ref_output_true,
    input wire logic [7:0] ref_output_complement
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    // Decode of the control group and the output block
    wire logic mapped = (wb_adr_i[7:2] == 6'h06) || (wb_adr_i[7:3] == 5'h04);
    wire logic wr_ack = wb_ack_o && wb_we_i && wb_sel_i;
    wire logic [2:0] out_idx = wb_adr_i[2:0];
    wire logic [1:0] amp_in = wb_dat_i[1:0];
    wire logic pd_in = wb_dat_i[2];
    wire logic en_in = wb_dat_i[4];
    // A fresh request and its answer one edge later; adr and dat stand until the ack edge
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_answer;
        ##1 (wb_ack_o || wb_err_o);
    endsequence
    a_req_answered: assert property (s_req |-> s_answer)
        else $error("request not answered in one cycle");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held over one cycle");
    a_err_one_pulse: assert property (wb_err_o |=> !wb_err_o)
        else $error("err held over one cycle");
    a_err_unmapped: assert property (wb_err_o |-> !mapped && !wb_ack_o)
        else $error("err on a mapped address");
    a_ack_mapped: assert property (wb_ack_o |-> mapped && wb_cyc_i && wb_stb_i)
        else $error("ack without a mapped request");
    a_gpd_write: assert property (wr_ack && wb_adr_i == 8'h18 |-> global_ref_power_down == wb_dat_i[7])
        else $error("global power-down not written");
    a_bias_write: assert property (wr_ack && wb_adr_i == 8'h19 |-> bias_type == wb_dat_i[7])
        else $error("bias type not written");
    a_gpd_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h18
        |-> wb_dat_o == {global_ref_power_down, 7'h00})
        else $error("control read data wrong");
    // Powered-down or disabled outputs ignore the amplitude field, so it reads zero there
    a_drv_follow: assert property (wr_ack && wb_adr_i[7:3] == 5'h04
        |=> out_drv[$past(out_idx)].powered == !($past(pd_in) || $past(global_ref_power_down))
        && out_drv[$past(out_idx)].amplitude == (($past(pd_in) || !$past(en_in)
        || $past(global_ref_power_down)) ? 2'h0 : $past(amp_in)))
        else $error("output state not applied");
    a_legs_exclusive: assert property ((ref_output_true & ref_output_complement) == 8'h00)
        else $error("both legs high");
endmodule : sro_top_chk

bind sro_top sro_top_chk i_chk (
    .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .wb_dat_o(wb_dat_o),
    .global_ref_power_down(global_ref_power_down), .bias_type(bias_type),
    .out_drv(out_drv), .ref_output_true(ref_output_true),
    .ref_output_complement(ref_output_complement)
);
`default_nettype wire

// file: bench/test_sysref_output_state_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_sysref_output_state_control;
    logic clk_sys, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, ref_in;
    logic wb_ack_o, wb_err_o, global_ref_power_down, bias_type;
    logic [7:0] wb_adr_i, wb_dat_i, wb_dat_o, ref_output_true, ref_output_complement;
    logic [1:0] delay_unit_multiplier;
    logic [8:0] calib_feedback_divider;
    logic [6:0] calib_input_divider_value;
    sro_pkg::sro_drv_t [7:0] out_drv;
    int n_errors, cmp_count;

    sro_top i_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .wb_dat_o(wb_dat_o), .ref_in(ref_in),
        .global_ref_power_down(global_ref_power_down), .bias_type(bias_type),
        .delay_unit_multiplier(delay_unit_multiplier),
        .calib_feedback_divider(calib_feedback_divider),
        .calib_input_divider_value(calib_input_divider_value), .out_drv(out_drv),
        .ref_output_true(ref_output_true), .ref_output_complement(ref_output_complement)
    );

    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic summarize;
        $display("Mismatches %0d, comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // One classic cycle; entered just after an edge, leaves one idle cycle behind
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                           output logic [7:0] rdat, output logic err);
        int n;
        n = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
            n_errors++;
            summarize();
        end
        rdat = wb_dat_o;
        err = wb_err_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        @(posedge clk_sys);
    endtask : wb_xfer

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [7:0] r;
        logic e;
        wb_xfer(1'b1, adr, dat, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
        logic [7:0] r;
        logic e;
        wb_xfer(1'b0, adr, 8'h00, r, e);
        chk(r === exp && e === 1'b0, "register read");
    endtask : rd

    task automatic t_reset_vals;
        chk(global_ref_power_down === 1'b1 && bias_type === 1'b1, "reset bits");
        rd(8'h18, 8'h80);
        rd(8'h19, 8'h80);
        rd(8'h1a, 8'h08);
        rd(8'h1b, 8'h08);
        for (int n = 0; n < 8; n++) begin
            rd(8'h20 + 8'(n), 8'h40);
        end
    endtask : t_reset_vals

    task automatic t_ctrl_map;
        logic [7:0] r;
        logic e;
        wr(8'h18, 8'hff);
        rd(8'h18, 8'h80);
        wr(8'h18, 8'h00);
        chk(global_ref_power_down === 1'b0, "power-up");
        wr(8'h19, 8'h41);
        rd(8'h19, 8'h41);
        chk(bias_type === 1'b0 && delay_unit_multiplier === 2'h2, "bias field");
        wr(8'h1a, 8'h5a);
        chk(calib_feedback_divider === 9'h15a, "feedback divider");
        wr(8'h1b, 8'hff);
        rd(8'h1b, 8'h7f);
        chk(calib_input_divider_value === 7'h7f, "input divider");
        wb_sel_i <= 1'b0;
        wr(8'h1b, 8'h01);
        wb_sel_i <= 1'b1;
        rd(8'h1b, 8'h7f);
        wb_xfer(1'b1, 8'h1c, 8'hff, r, e);
        chk(e === 1'b1, "unmapped address");
    endtask : t_ctrl_map

    // Every amplitude code, both formats and both sources across the eight outputs
    task automatic t_out_fields;
        logic [7:0] v;
        for (int n = 0; n < 8; n++) begin
            v = {1'b0, n[0], 2'b01, n[1], 1'b0, n[1:0]};
            wr(8'h20 + 8'(n), v);
            rd(8'h20 + 8'(n), v);
            chk(out_drv[n].amplitude === n[1:0] && out_drv[n].ecl_format === n[1]
                && out_drv[n].use_sysref === n[0] && out_drv[n].powered === 1'b1, "fields");
        end
    endtask : t_out_fields

    task automatic t_pd_disable;
        wr(8'h23, 8'h5f);
        wr(8'h21, 8'h40);
        ref_in <= 1'b1;
        cyc(5);
        chk(out_drv[3].powered === 1'b0 && ref_output_true[3] === 1'b0
            && ref_output_complement[3] === 1'b0
            && out_drv[3].true_leg === sro_pkg::SRO_LEG_OFF, "power-down");
        chk(out_drv[1].true_leg === sro_pkg::SRO_LEG_LOW && ref_output_true[1] === 1'b0
            && ref_output_complement[1] === 1'b0, "disabled low");
        ref_in <= 1'b0;
        cyc(2);
    endtask : t_pd_disable

    // Expected idle state of output 0 for a bias type
    function automatic logic idle_ok(input logic bias);
        if (bias) begin
            return out_drv[0].true_leg === sro_pkg::SRO_LEG_XPOINT
                && out_drv[0].comp_leg === sro_pkg::SRO_LEG_XPOINT
                && ref_output_true[0] === 1'b0 && ref_output_complement[0] === 1'b0;
        end
        return out_drv[0].true_leg === sro_pkg::SRO_LEG_LOW && ref_output_true[0] === 1'b0
            && ref_output_complement[0] === 1'b1;
    endfunction : idle_ok

    // All four bias and pre-bias pairs, idle then after a reference rise
    task automatic t_bias_modes;
        // Disable first: the earlier reference rise left output 0 armed
        wr(8'h20, 8'h40);
        for (int m = 0; m < 4; m++) begin
            wr(8'h19, {m[1], 7'h00});
            wr(8'h20, {2'b01, m[0], 5'h10});
            chk(idle_ok(m[1]), "idle level");
            ref_in <= 1'b1;
            cyc(5);
            if (m[0]) begin
                chk(idle_ok(m[1]), "static level");
            end else begin
                chk(out_drv[0].true_leg === sro_pkg::SRO_LEG_TOGGLE
                    && ref_output_true[0] === 1'b1, "toggling");
            end
            ref_in <= 1'b0;
            wr(8'h20, 8'h40);
        end
    endtask : t_bias_modes

    // Emitter-coupled output ignores bias type and pre-bias
    task automatic t_ecl;
        wr(8'h19, 8'h80);
        // Disable first: earlier reference rises left output 2 armed
        wr(8'h22, 8'h40);
        wr(8'h22, 8'h78);
        chk(out_drv[2].true_leg === sro_pkg::SRO_LEG_LOW && ref_output_true[2] === 1'b0, "ecl idle");
        ref_in <= 1'b1;
        cyc(5);
        chk(out_drv[2].true_leg === sro_pkg::SRO_LEG_TOGGLE, "ecl toggle");
        ref_in <= 1'b0;
        cyc(2);
    endtask : t_ecl

    initial begin
        n_errors = 0;
        cmp_count = 0;
        arst_n = 1'b0;
        wb_sel_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, ref_in} = '0;
        cyc(3);
        arst_n <= 1'b1;
        cyc(1);
        t_reset_vals();
        t_ctrl_map();
        t_out_fields();
        t_pd_disable();
        t_bias_modes();
        t_ecl();
        summarize();
    end
endmodule : test_sysref_output_state_control
`default_nettype wire
